// [rtl/aiof_axis.sv]
`timescale 1ns/1ps
`default_nettype none
// one axis: average, incremental and integrated forms of one sample stream
module aiof_axis
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control
   input wire logic sampleTick,
   input wire logic sendTick,
   input wire logic incl,
   input wire aiof_pkg::aiof_mode_t mode,
   input wire aiof_pkg::aiof_range_t range,
   // sample, g scaled by 2^20
   input wire logic signed [aiof_pkg::WORD_W-1:0] sampleIn,
   // formatted word
   output logic [aiof_pkg::WORD_W-1:0] word
);
   typedef struct packed {
      logic signed [aiof_pkg::ACC_W-1:0] avgSum;
      logic [aiof_pkg::CNT_W-1:0] avgCnt;
      logic signed [aiof_pkg::ACC_W-1:0] velInt;
      logic signed [aiof_pkg::WORD_W-1:0] lastSample;
      logic [aiof_pkg::WORD_W-1:0] word;
   } aiof_axis_t;

   aiof_axis_t st;
   aiof_axis_t next_st;
   logic signed [aiof_pkg::ACC_W-1:0] velInc;
   logic signed [aiof_pkg::ACC_W-1:0] avg;

   // ==========================================
   // shift a 40-bit fixed value from frac bits fin to fout
   function automatic logic [aiof_pkg::WORD_W-1:0] rescale(
      input logic signed [aiof_pkg::ACC_W-1:0] v, input logic [4:0] fin, input logic [4:0] fout);
      logic signed [aiof_pkg::ACC_W-1:0] t;
      t = (fout >= fin) ? (v <<< (fout - fin)) : (v >>> (fin - fout));
      return t[aiof_pkg::WORD_W-1:0];
   endfunction : rescale

   function automatic logic [4:0] velFrac(input aiof_pkg::aiof_range_t r);
      unique case (r)
         aiof_pkg::RANGE_5G: return aiof_pkg::VEL_FRAC_5G;
         aiof_pkg::RANGE_10G: return aiof_pkg::VEL_FRAC_10G;
         aiof_pkg::RANGE_30G: return aiof_pkg::VEL_FRAC_30G;
         aiof_pkg::RANGE_80G: return aiof_pkg::VEL_FRAC_80G;
      endcase
   endfunction : velFrac

   function automatic logic [4:0] accFrac(input aiof_pkg::aiof_range_t r, input logic inc);
      logic [4:0] s;
      s = aiof_pkg::ACC_SHIFT_5G;
      unique case (r)
         aiof_pkg::RANGE_5G: s = aiof_pkg::ACC_SHIFT_5G;
         aiof_pkg::RANGE_10G: s = aiof_pkg::ACC_SHIFT_10G;
         aiof_pkg::RANGE_30G: s = aiof_pkg::ACC_SHIFT_30G;
         aiof_pkg::RANGE_80G: s = aiof_pkg::ACC_SHIFT_80G;
      endcase
      return inc ? aiof_pkg::INC_ACC_FRAC : 5'(aiof_pkg::SAMPLE_FRAC) - s;
   endfunction : accFrac

   // ==========================================
   // per-sample velocity, frac VEL_INT_FRAC
   assign velInc = ((aiof_pkg::ACC_W)'(st.lastSample) * $signed({1'b0, aiof_pkg::G_MUL}))
      >>> (aiof_pkg::G_SH + aiof_pkg::SAMPLE_FRAC - aiof_pkg::VEL_INT_FRAC);

   always_comb
   begin
      next_st = st;
      avg = (st.avgCnt == '0) ? (aiof_pkg::ACC_W)'(st.lastSample)
         : st.avgSum / $signed({1'b0, (aiof_pkg::ACC_W-1)'(st.avgCnt)});
      if (sampleTick)
      begin
         next_st.lastSample = sampleIn;
         next_st.avgSum = st.avgSum + (aiof_pkg::ACC_W)'(sampleIn);
         next_st.avgCnt = st.avgCnt + 1'b1;
      end
      if (sampleTick && !incl)
      begin
         // free-running sum; only low 24 bits of the scaled word leave, so it wraps
         next_st.velInt = st.velInt + velInc;
      end
      if (sendTick)
      begin
         unique case (mode)
            aiof_pkg::MODE_ACC:
               next_st.word = rescale((aiof_pkg::ACC_W)'(st.lastSample),
                  5'(aiof_pkg::SAMPLE_FRAC), accFrac(range, incl));
            aiof_pkg::MODE_AVG:
               next_st.word = rescale(avg, 5'(aiof_pkg::SAMPLE_FRAC), accFrac(range, incl));
            aiof_pkg::MODE_INCVEL:
               next_st.word = rescale(velInc, aiof_pkg::VEL_INT_FRAC,
                  incl ? aiof_pkg::INC_VEL_FRAC : velFrac(range));
            aiof_pkg::MODE_INTVEL:
               next_st.word = rescale(st.velInt, aiof_pkg::VEL_INT_FRAC, velFrac(range));
         endcase
         // samples landing on the send cycle start the next average
         next_st.avgSum = sampleTick ? (aiof_pkg::ACC_W)'(sampleIn) : '0;
         next_st.avgCnt = sampleTick ? (aiof_pkg::CNT_W)'(1) : '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign word = st.word;
endmodule : aiof_axis
`default_nettype wire

// [rtl/aiof_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
module aiof_formatter
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // configuration
   input wire aiof_pkg::aiof_mode_t accelMode,
   input wire aiof_pkg::aiof_mode_t inclMode,
   input wire aiof_pkg::aiof_range_t range,
   // samples, signed g scaled by 2^20, one per axis
   input wire logic [3*aiof_pkg::WORD_W-1:0] accelIn,
   input wire logic [3*aiof_pkg::WORD_W-1:0] inclIn,
   // datagram request
   input wire logic sendReq,
   // internal sample strobe
   output logic sampleStrobe,
   // formatted bytes, axis x..z, msb first
   output logic [3*8-1:0] accel_byte_high,
   output logic [3*8-1:0] accel_byte_mid,
   output logic [3*8-1:0] accel_byte_low,
   output logic [3*8-1:0] vel_byte_high,
   output logic [3*8-1:0] vel_byte_mid,
   output logic [3*8-1:0] vel_byte_low,
   output logic dataValid
);
   typedef struct packed {
      logic [14:0] div;
      logic tick;
      logic valid;
   } aiof_top_t;

   aiof_top_t st;
   aiof_top_t next_st;
   logic [2*aiof_pkg::AXES*aiof_pkg::WORD_W-1:0] words;

   // ==========================================
   // fixed 2000 Hz sample clock
   always_comb
   begin
      next_st = st;
      next_st.tick = (st.div == aiof_pkg::SAMPLE_LAST);
      next_st.div = next_st.tick ? '0 : st.div + 15'h0001;
      next_st.valid = sendReq;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign sampleStrobe = st.tick;
   assign dataValid = st.valid;

   // ==========================================
   genvar g;
   generate
      for (g = 0; g < 2*aiof_pkg::AXES; g++)
      begin : gAxis
         aiof_axis uAxis
         (
            .mclk(mclk),
            .rst(rst),
            .sampleTick(st.tick),
            .sendTick(sendReq),
            .incl(g >= aiof_pkg::AXES),
            .mode(g >= aiof_pkg::AXES ? inclMode : accelMode),
            .range(range),
            .sampleIn(g >= aiof_pkg::AXES ? inclIn[(g % aiof_pkg::AXES)*24 +: 24]
               : accelIn[(g % aiof_pkg::AXES)*24 +: 24]),
            .word(words[g*24 +: 24])
         );
      end
      for (g = 0; g < aiof_pkg::AXES; g++)
      begin : gBytes
         // msb-first byte split
         assign accel_byte_high[g*8 +: 8] = words[g*24+16 +: 8];
         assign accel_byte_mid[g*8 +: 8] = words[g*24+8 +: 8];
         assign accel_byte_low[g*8 +: 8] = words[g*24 +: 8];
         assign vel_byte_high[g*8 +: 8] = words[(g+3)*24+16 +: 8];
         assign vel_byte_mid[g*8 +: 8] = words[(g+3)*24+8 +: 8];
         assign vel_byte_low[g*8 +: 8] = words[(g+3)*24 +: 8];
      end
   endgenerate
endmodule : aiof_formatter
`default_nettype wire

// [rtl/aiof_pkg.sv]
// Behaviour
// - accel incremental velocity: 24-bit, range-scaled, MSB first
// - average mode: mean of samples since last send
// - average uses plain acceleration encoding
// - acceleration word scaled by 2^20/19/18/16
// - integrated velocity accumulates since reset on accelerometer axes; inclinometer integral stays zero
// - integrated velocity not limited to range interval
// - integrated velocity wraps, no error flag
// - integrated velocity uses accel incremental velocity encoding (range-scaled), also on inclinometer axes
// - inclinometer acceleration scaled by 2^22
// - inclinometer incremental velocity scaled by 2^25
// - internal sampling fixed at 2000 per second
package aiof_pkg;
   // ==========================================
   // timing
   localparam int CLK_HZ = 40000000;
   localparam int SAMPLE_HZ = 2000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam logic [14:0] SAMPLE_LAST = 15'(SAMPLE_CYCLES - 1);
   // ==========================================
   // widths and formats
   localparam int WORD_W = 24;
   localparam int ACC_W = 40;
   localparam int CNT_W = 12;
   localparam int AXES = 3;
   // ==========================================
   // input sample: signed g scaled by 2^SAMPLE_FRAC
   localparam int SAMPLE_FRAC = 20;
   // accelerometer acceleration word shifts per range (2^20,2^19,2^18,2^16)
   localparam logic [4:0] ACC_SHIFT_5G = 5'h00;
   localparam logic [4:0] ACC_SHIFT_10G = 5'h01;
   localparam logic [4:0] ACC_SHIFT_30G = 5'h02;
   localparam logic [4:0] ACC_SHIFT_80G = 5'h04;
   // velocity per sample: g*9.80665/2000 ~ g * G_MUL / 2^G_SH
   localparam logic [15:0] G_MUL = 16'h282B;
   localparam int G_SH = 21;
   // velocity word frac bits per range (2^23,2^22,2^21,2^19)
   localparam logic [4:0] VEL_FRAC_5G = 5'h17;
   localparam logic [4:0] VEL_FRAC_10G = 5'h16;
   localparam logic [4:0] VEL_FRAC_30G = 5'h15;
   localparam logic [4:0] VEL_FRAC_80G = 5'h13;
   localparam logic [4:0] INC_ACC_FRAC = 5'h16;
   localparam logic [4:0] INC_VEL_FRAC = 5'h19;
   localparam logic [4:0] VEL_INT_FRAC = 5'h19;
   // ==========================================
   typedef enum logic [1:0] {RANGE_5G, RANGE_10G, RANGE_30G, RANGE_80G} aiof_range_t;
   typedef enum logic [1:0] {MODE_ACC, MODE_INCVEL, MODE_AVG, MODE_INTVEL} aiof_mode_t;
endpackage : aiof_pkg

// [test/aiof_formatter_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module aiof_formatter_monitor
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // configuration, samples, request
   input wire aiof_pkg::aiof_mode_t accelMode,
   input wire aiof_pkg::aiof_mode_t inclMode,
   input wire aiof_pkg::aiof_range_t range,
   input wire logic [71:0] accelIn,
   input wire logic [71:0] inclIn,
   input wire logic sendReq,
   // outputs
   input wire logic sampleStrobe,
   input wire logic [23:0] accel_byte_high,
   input wire logic [23:0] accel_byte_mid,
   input wire logic [23:0] accel_byte_low,
   input wire logic [23:0] vel_byte_high,
   input wire logic [23:0] vel_byte_mid,
   input wire logic [23:0] vel_byte_low,
   input wire logic dataValid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [14:0] gap;
   logic seen;
   logic [23:0] lastAcc;
   logic [23:0] lastIncl;
   // cycles since strobe, last axis x samples
   always_ff @(posedge mclk)
   begin
      gap <= (rst || sampleStrobe) ? 15'h0 : gap + 15'h1;
      seen <= !rst && (seen || sampleStrobe);
      lastAcc <= rst ? 24'h0 : (sampleStrobe ? accelIn[23:0] : lastAcc);
      lastIncl <= rst ? 24'h0 : (sampleStrobe ? inclIn[23:0] : lastIncl);
   end
   property p_validAfterSend; sendReq |=> dataValid; endproperty
   a_validAfterSend: assert property (p_validAfterSend) else $error("no valid after send");
   property p_noSpurious; !sendReq |=> !dataValid; endproperty
   a_noSpurious: assert property (p_noSpurious) else $error("valid without send");
   property p_accHold;
      !dataValid |-> $stable({accel_byte_high, accel_byte_mid, accel_byte_low});
   endproperty
   a_accHold: assert property (p_accHold) else $error("accel bytes moved");
   property p_velHold; !dataValid |-> $stable({vel_byte_high, vel_byte_mid, vel_byte_low});
   endproperty
   a_velHold: assert property (p_velHold) else $error("vel bytes moved");
   property p_strobePulse; sampleStrobe |=> !sampleStrobe; endproperty
   a_strobePulse: assert property (p_strobePulse) else $error("strobe too long");
   property p_strobePeriod; seen && sampleStrobe |-> gap == 15'h4E1F; endproperty
   a_strobePeriod: assert property (p_strobePeriod) else $error("strobe early");
   property p_strobeDue; seen |-> gap < 15'h4E20; endproperty
   a_strobeDue: assert property (p_strobeDue) else $error("strobe late");
   property p_accWord;
      dataValid && $past(accelMode) == aiof_pkg::MODE_ACC && $past(range) == aiof_pkg::RANGE_5G
         && !$past(sampleStrobe) |-> {accel_byte_high[7:0], accel_byte_mid[7:0],
         accel_byte_low[7:0]} == lastAcc;
   endproperty
   a_accWord: assert property (p_accWord) else $error("accel word wrong");
   property p_inclWord;
      dataValid && $past(inclMode) == aiof_pkg::MODE_ACC && !$past(sampleStrobe)
         |-> {vel_byte_high[7:0], vel_byte_mid[7:0], vel_byte_low[7:0]} == {lastIncl[21:0], 2'h0};
   endproperty
   a_inclWord: assert property (p_inclWord) else $error("incl word wrong");
endmodule : aiof_formatter_monitor
bind aiof_formatter aiof_formatter_monitor aiof_formatter_monitor_inst (.*);
`default_nettype wire

// [test/aiof_formatter_test.sv]
`timescale 1ns/1ps
`default_nettype none
module aiof_formatter_test;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   aiof_pkg::aiof_mode_t accelMode = aiof_pkg::MODE_ACC;
   aiof_pkg::aiof_mode_t inclMode = aiof_pkg::MODE_ACC;
   aiof_pkg::aiof_range_t range = aiof_pkg::RANGE_5G;
   logic [71:0] accelIn = 72'h0;
   logic [71:0] inclIn = 72'h0;
   logic sendReq = 1'h0;
   wire logic sampleStrobe, dataValid, wordValid;
   wire logic [23:0] accel_byte_high, accel_byte_mid, accel_byte_low;
   wire logic [23:0] vel_byte_high, vel_byte_mid, vel_byte_low;
   wire logic [95:0] accelWord, inclWord;
   logic [191:0] expQ [$];
   logic [191:0] e;
   logic [191:0] eVel;
   logic [191:0] eInt;
   logic [191:0] want;
   logic [191:0] got;
   longint velAcc [3] = '{0, 0, 0};
   longint step;
   int sh;
   logic [31:0] x;
   int miscompares = 0;
   int checks = 0;
   int seed = 32'h44C4F5FD;
   aiof_formatter aiof_formatter_inst (.*);
   aiof_host aiof_host_inst (.*);
   always #12.5 mclk = ~mclk;
   task automatic cmp(input logic [31:0] g, input logic [31:0] w);
      checks++;
      if (g !== w)
         miscompares++;
      if (g !== w)
         $display("ERROR t=%0t got=%h exp=%h", $time, g, w);
   endtask : cmp
   task automatic tally_and_finish();
      if (expQ.size() != 0)
         miscompares++;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic send();
      @(posedge mclk);
      sendReq <= 1'h1;
      @(posedge mclk);
      sendReq <= 1'h0;
   endtask : send
   // sign-extend the low 24 bits as the host does
   function automatic logic [31:0] sx(input longint v);
      return {{8{v[23]}}, v[23:0]};
   endfunction : sx
   // velocity per sample at 2^25 for a sample of g at 2^20
   function automatic longint velStep(input logic [23:0] s);
      return (longint'($signed(s)) * longint'(aiof_pkg::G_MUL))
         >>> (aiof_pkg::G_SH + aiof_pkg::SAMPLE_FRAC - 25);
   endfunction : velStep
   // ==========================================
   // result checker
   always @(negedge mclk)
      if (wordValid === 1'b1)
      begin
         got = {inclWord, accelWord};
         if (expQ.size() == 0)
            cmp(32'h1, 32'h0);
         else
         begin
            want = expQ.pop_front();
            for (int k = 0; k < 6; k++)
               cmp(got[32*k+:32], want[32*k+:32]);
         end
      end
   // ==========================================
   // stimulus: zero after reset, then each range
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      expQ.push_back(192'h0);
      send();
      for (int r = 0; r < 4; r++)
      begin
         @(posedge mclk);
         range <= aiof_pkg::aiof_range_t'(r[1:0]);
         accelMode <= r[0] ? aiof_pkg::MODE_AVG : aiof_pkg::MODE_ACC;
         inclMode <= aiof_pkg::MODE_ACC;
         // shift from 2^25 down to the range's velocity scale
         sh = (r == 3) ? 6 : r + 2;
         for (int k = 0; k < 3; k++)
         begin
            x = $random(seed) & 32'h00FFFFF0;
            accelIn[24*k+:24] <= x[23:0];
            e[32*k+:32] = $signed({{8{x[23]}}, x[23:0]}) >>> ((r == 3) ? 4 : r);
            step = velStep(x[23:0]);
            eVel[32*k+:32] = sx(step >>> sh);
            // integral holds every earlier sample, not the one just taken
            eInt[32*k+:32] = sx(velAcc[k] >>> sh);
            velAcc[k] += step;
            x = $random(seed);
            inclIn[24*k+:24] <= {{2{x[21]}}, x[21:0]};
            e[96+32*k+:32] = {{8{x[21]}}, x[21:0], 2'h0};
            eVel[96+32*k+:32] = sx(velStep({{2{x[21]}}, x[21:0]}));
            // average with no sample since the last send is the last sample
            eInt[96+32*k+:32] = e[96+32*k+:32];
         end
         expQ.push_back(e);
         expQ.push_back(eVel);
         expQ.push_back(eInt);
         do @(negedge mclk); while (sampleStrobe !== 1'b1);
         send();
         accelMode <= aiof_pkg::MODE_INCVEL;
         inclMode <= aiof_pkg::MODE_INCVEL;
         send();
         accelMode <= aiof_pkg::MODE_INTVEL;
         inclMode <= aiof_pkg::MODE_AVG;
         send();
         $display("range test %0d done", r);
      end
      repeat (4) @(posedge mclk);
      tally_and_finish();
   end
   initial
   begin
      #2200000;
      miscompares++;
      tally_and_finish();
   end
endmodule : aiof_formatter_test
`default_nettype wire

// [test/aiof_host.sv]
`timescale 1ns/1ps
`default_nettype none
module aiof_host
(
   // clock
   input wire logic mclk,
   // received bytes
   input wire logic [23:0] accel_byte_high,
   input wire logic [23:0] accel_byte_mid,
   input wire logic [23:0] accel_byte_low,
   input wire logic [23:0] vel_byte_high,
   input wire logic [23:0] vel_byte_mid,
   input wire logic [23:0] vel_byte_low,
   input wire logic dataValid,
   // rebuilt words, sign-extended
   output logic [95:0] accelWord,
   output logic [95:0] inclWord,
   output logic wordValid
);
   always_ff @(posedge mclk)
   begin
      wordValid <= dataValid;
      for (int k = 0; k < 3; k++)
      begin
         accelWord[32*k+:32] <= {{8{accel_byte_high[8*k+7]}}, accel_byte_high[8*k+:8],
            accel_byte_mid[8*k+:8], accel_byte_low[8*k+:8]};
         inclWord[32*k+:32] <= {{8{vel_byte_high[8*k+7]}}, vel_byte_high[8*k+:8],
            vel_byte_mid[8*k+:8], vel_byte_low[8*k+:8]};
      end
   end
endmodule : aiof_host
`default_nettype wire
